// [lcd_pkg.sv]
// Functional notes
// - reset stops bias and drivers, all common and segment outputs at ground
// - software picks 1/3 or 1/4 bias, multiplier lock; bias on bit enables
// - frame frequency and duty select the common scanning
// - allocation off: display registers mapped by one of three fixed maps
// - enable bit off: both allocation arrays serve as 1 KB data RAM
// - allocation on: each segment/common bit taken from allocation arrays
// - allocation only at 64/73/85/102 Hz with duty up to 1/8,1/7,1/6,1/5
// - duty 1/9 to 1/24 never uses allocation, whatever the enable holds
// - first entry holds register address low byte, second the bit number
// - arrays loaded with the enable bit off; accesses ignored while the enable bit is on, even where allocation is not in use
package lcd_pkg;
  localparam int CLK_HZ     = 100_000_000;
  localparam int FRAME_HZ_0 = 64;
  localparam int FRAME_HZ_1 = 73;
  localparam int FRAME_HZ_2 = 85;
  localparam int FRAME_HZ_3 = 102;
  localparam int FRAME_CYC_0 = CLK_HZ / FRAME_HZ_0;
  localparam int FRAME_CYC_1 = CLK_HZ / FRAME_HZ_1;
  localparam int FRAME_CYC_2 = CLK_HZ / FRAME_HZ_2;
  localparam int FRAME_CYC_3 = CLK_HZ / FRAME_HZ_3;
  localparam int ACC_W       = 21;
  localparam int SEGS        = 64;
  localparam int COMS        = 24;
  localparam int ALLOC_WORDS = 512;
  localparam int DISP_WORDS  = 256;
  localparam logic [4:0] MAX_DUTY   = 5'h18;
  localparam logic [4:0] ALLOC_DUTY_0 = 5'h08;
  localparam logic [4:0] ALLOC_DUTY_1 = 5'h07;
  localparam logic [4:0] ALLOC_DUTY_2 = 5'h06;
  localparam logic [4:0] ALLOC_DUTY_3 = 5'h05;
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MAP_TYPE1  = 2'h0;
  localparam logic [1:0] MAP_TYPE2  = 2'h1;
  localparam logic [1:0] FREQ_64    = 2'h0;
  localparam logic [1:0] FREQ_73    = 2'h1;
  localparam logic [1:0] FREQ_85    = 2'h2;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [4:0] COM_RST    = 5'h00;
endpackage

// [lcd_drive_segment_allocation.sv]
`timescale 1ns/10ps
module lcd_drive_segment_allocation
#(
  parameter int FRAME_CYC_64  = lcd_pkg::FRAME_CYC_0,
  parameter int FRAME_CYC_73  = lcd_pkg::FRAME_CYC_1,
  parameter int FRAME_CYC_85  = lcd_pkg::FRAME_CYC_2,
  parameter int FRAME_CYC_102 = lcd_pkg::FRAME_CYC_3
)
(
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic                       bias_on_bit,
  input  wire logic                       bias_third_sel,
  input  wire logic                       bias_mult_lock,
  input  wire logic [1:0]                 frame_freq_sel,
  input  wire logic [4:0]                 duty_sel,
  input  wire logic                       alloc_enable_bit,
  input  wire logic                       map_type_sel_hi,
  input  wire logic                       map_type_sel_lo,
  input  wire logic                       display_mode_sel_hi,
  input  wire logic                       display_mode_sel_lo,
  input  wire logic                       disp_wr,
  input  wire logic [7:0]                 disp_addr,
  input  wire logic [7:0]                 disp_wdata,
  input  wire logic                       alloc_wr,
  input  wire logic                       alloc_rd,
  input  wire logic [9:0]                 alloc_addr,
  input  wire logic [7:0]                 alloc_wdata,
  output logic      [7:0]                 alloc_rdata,
  output logic                            bias_gen_on,
  output logic                            bias_third,
  output logic                            mult_locked,
  output logic                            drivers_on,
  output logic      [lcd_pkg::COMS-1:0]   com_out,
  output logic      [lcd_pkg::SEGS-1:0]   seg_out
);
  import lcd_pkg::*;

  logic [7:0]       disp_mem [DISP_WORDS];
  logic [7:0]       alloc_a  [ALLOC_WORDS];
  logic [7:0]       alloc_b  [ALLOC_WORDS];
  logic [4:0]       com_idx;
  logic [ACC_W-1:0] acc;
  logic [4:0]       next_com_idx;
  logic [ACC_W-1:0] next_acc;
  logic [7:0]       next_alloc_rdata;
  logic             next_bias_gen_on;
  logic             next_bias_third;
  logic             next_mult_locked;
  logic             next_drivers_on;
  logic [COMS-1:0]  next_com_out;
  logic [SEGS-1:0]  next_seg_out;
  logic [SEGS-1:0]  pix;
  logic [4:0]       duty;
  logic             use_alloc;
  logic [1:0]       map_type;
  logic [ACC_W-1:0] frame_cyc;
  logic [ACC_W-1:0] acc_sum;
  logic [4:0]       com_inc;
  logic             rd_en;
  logic             a_wr_en;
  logic             b_wr_en;

  // number of commons scanned, 1 to 24
  function automatic logic [4:0] duty_len(input logic [4:0] sel);
    duty_len = (sel >= MAX_DUTY) ? MAX_DUTY : 5'(sel + 5'h01);
  endfunction

  // frequency/duty pairs that allow programmable allocation
  function automatic logic alloc_ok(input logic [1:0] freq,
                                    input logic [4:0] d);
    unique case (freq)
      FREQ_64: alloc_ok = (d <= ALLOC_DUTY_0);
      FREQ_73: alloc_ok = (d <= ALLOC_DUTY_1);
      FREQ_85: alloc_ok = (d <= ALLOC_DUTY_2);
      default: alloc_ok = (d <= ALLOC_DUTY_3);
    endcase
  endfunction

  // display register holding a segment/common pair under a fixed map
  function automatic logic [7:0] fixed_addr(input logic [1:0] mt,
                                            input logic [5:0] seg,
                                            input logic [4:0] com);
    logic [9:0] t1;
    t1 = 10'({seg, 1'b0}) + 10'(seg) + 10'(com[4:3]);
    if (mt == MAP_TYPE1)
      fixed_addr = t1[7:0];
    else if (mt == MAP_TYPE2)
      fixed_addr = {1'b0, seg, com[3]};
    else
      fixed_addr = {com[4:3], seg};
  endfunction

  // array strobe from the processor, dropped while allocation is on
  function automatic logic cpu_access(input logic strobe,
                                      input logic alloc_on);
    cpu_access = strobe && !alloc_on;
  endfunction

  always_comb
  begin
    duty = duty_len(duty_sel);
    map_type = map_type_sel_hi ? 2'h2 : {1'b0, map_type_sel_lo};
    use_alloc = alloc_enable_bit && alloc_ok(frame_freq_sel, duty);
    unique case (frame_freq_sel)
      FREQ_64: frame_cyc = ACC_W'(FRAME_CYC_64);
      FREQ_73: frame_cyc = ACC_W'(FRAME_CYC_73);
      FREQ_85: frame_cyc = ACC_W'(FRAME_CYC_85);
      default: frame_cyc = ACC_W'(FRAME_CYC_102);
    endcase
  end

  // one pixel per segment for the common now being scanned
  genvar g;
  generate
    for (g = 0; g < SEGS; g++)
    begin : seg_pix
      logic [7:0] fa;
      logic [8:0] ai;
      always_comb
      begin
        fa = fixed_addr(map_type, 6'(g), com_idx);
        ai = {6'(g), com_idx[2:0]};
        if (use_alloc)
          pix[g] = disp_mem[alloc_a[ai]][alloc_b[ai][2:0]];
        else
          pix[g] = disp_mem[fa][com_idx[2:0]];
      end
    end
  endgenerate

  // bias enables follow the control bits one clock late; drivers_on follows the mode bits and bias_gen_on one clock late
  always_comb
  begin
    next_bias_gen_on = bias_on_bit;
    next_bias_third = bias_third_sel;
    next_mult_locked = bias_mult_lock;
    next_drivers_on = bias_gen_on &&
      ({display_mode_sel_hi, display_mode_sel_lo} != MODE_OFF);
  end

  // common scan and the registered pixel row
  always_comb
  begin
    acc_sum = acc + ACC_W'(duty);
    com_inc = 5'(com_idx + 5'h01);
    next_acc = acc;
    next_com_idx = com_idx;
    if (!drivers_on)
    begin
      next_acc = '0;
      next_com_idx = COM_RST;
    end
    else if (com_idx >= duty)
      next_com_idx = COM_RST;
    else if (acc_sum >= frame_cyc)
    begin
      // step rate is frame rate times duty
      next_acc = acc_sum - frame_cyc;
      next_com_idx = (com_inc >= duty) ? COM_RST : com_inc;
    end
    else
      next_acc = acc_sum;
    next_com_out = '0;
    next_seg_out = '0;
    if (drivers_on)
    begin
      next_com_out[com_idx] = 1'b1;
      next_seg_out = pix;
    end
  end

  // allocation array port, one access per strobe
  always_comb
  begin
    rd_en = cpu_access(alloc_rd, alloc_enable_bit);
    a_wr_en = cpu_access(alloc_wr, alloc_enable_bit) && !alloc_addr[9];
    b_wr_en = cpu_access(alloc_wr, alloc_enable_bit) && alloc_addr[9];
    next_alloc_rdata = BYTE_RST;
    if (rd_en)
      next_alloc_rdata = alloc_addr[9] ? alloc_b[alloc_addr[8:0]]
                                       : alloc_a[alloc_addr[8:0]];
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bias_gen_on <= 1'b0;
      bias_third  <= 1'b0;
      mult_locked <= 1'b0;
      drivers_on  <= 1'b0;
      com_out     <= '0;
      seg_out     <= '0;
      com_idx     <= COM_RST;
      acc         <= '0;
      alloc_rdata <= BYTE_RST;
    end
    else
    begin
      bias_gen_on <= next_bias_gen_on;
      bias_third  <= next_bias_third;
      mult_locked <= next_mult_locked;
      drivers_on  <= next_drivers_on;
      com_out     <= next_com_out;
      seg_out     <= next_seg_out;
      com_idx     <= next_com_idx;
      acc         <= next_acc;
      alloc_rdata <= next_alloc_rdata;
    end
  end

  // storage arrays, no reset
  always_ff @(posedge core_clk)
  begin
    if (disp_wr)
      disp_mem[disp_addr] <= disp_wdata;
    if (a_wr_en)
      alloc_a[alloc_addr[8:0]] <= alloc_wdata;
    if (b_wr_en)
      alloc_b[alloc_addr[8:0]] <= alloc_wdata;
  end
endmodule

// [lcd_panel_model.sv]
`timescale 1ns/10ps
module lcd_panel_model
(
  input  wire logic [23:0] com_out,
  output logic      [4:0]  lit_com
);
  // index of the common the glass sees driven
  always_comb
  begin
    lit_com = 5'h00;
    for (int i = 0; i < 24; i++)
      if (com_out[i])
        lit_com = 5'(i);
  end
endmodule

// [lcd_drive_segment_allocation_asserts.sv]
`timescale 1ns/10ps
module lcd_sa_checker
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        bias_on_bit,
  input wire logic        bias_third_sel,
  input wire logic        bias_mult_lock,
  input wire logic        bias_third,
  input wire logic        mult_locked,
  input wire logic        display_mode_sel_hi,
  input wire logic        display_mode_sel_lo,
  input wire logic        alloc_enable_bit,
  input wire logic        alloc_rd,
  input wire logic [7:0]  alloc_rdata,
  input wire logic        bias_gen_on,
  input wire logic        drivers_on,
  input wire logic [23:0] com_out,
  input wire logic [63:0] seg_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  bias_rise_a: assert property ($rose(bias_on_bit) |=> bias_gen_on)
    else $error("bias generator missed enable");
  bias_copy_a: assert property (
    bias_third == $past(bias_third_sel) &&
    mult_locked == $past(bias_mult_lock))
    else $error("bias select not copied");
  mode_off_a: assert property (
    !(display_mode_sel_hi || display_mode_sel_lo) |=> !drivers_on)
    else $error("drivers on outside display mode");
  off_ground_a: assert property (
    !drivers_on |=> com_out == '0 && seg_out == '0)
    else $error("pins not grounded while drivers off");
  seg_idle_a: assert property (com_out == '0 |-> seg_out == '0)
    else $error("segment driven with no common");
  com_onehot_a: assert property (com_out != '0 |-> $onehot(com_out))
    else $error("more than one common driven");
  com_first_a: assert property (
    $rose(drivers_on) |=> com_out == 24'h00_0001)
    else $error("scan did not start at common 0");
  rd_block_a: assert property (
    alloc_rd && alloc_enable_bit |=> alloc_rdata == 8'h00)
    else $error("array read while allocation on");
  rd_idle_a: assert property (!alloc_rd |=> alloc_rdata == 8'h00)
    else $error("read data without read");
endmodule
bind lcd_drive_segment_allocation lcd_sa_checker chk (
  .core_clk            (core_clk),
  .rstn                (rstn),
  .bias_on_bit         (bias_on_bit),
  .bias_third_sel      (bias_third_sel),
  .bias_mult_lock      (bias_mult_lock),
  .bias_third          (bias_third),
  .mult_locked         (mult_locked),
  .display_mode_sel_hi (display_mode_sel_hi),
  .display_mode_sel_lo (display_mode_sel_lo),
  .alloc_enable_bit    (alloc_enable_bit),
  .alloc_rd            (alloc_rd),
  .alloc_rdata         (alloc_rdata),
  .bias_gen_on         (bias_gen_on),
  .drivers_on          (drivers_on),
  .com_out             (com_out),
  .seg_out             (seg_out)
);

// [lcd_drive_segment_allocation_test.sv]
`timescale 1ns/10ps
module lcd_drive_segment_allocation_test;
  localparam int TBIAS = 20;
  logic core_clk = 0, rstn = 0, bias_on_bit = 0, bias_third_sel = 0;
  logic bias_mult_lock = 0, alloc_enable_bit = 0, map_type_sel_hi = 0;
  logic map_type_sel_lo = 0, display_mode_sel_hi = 0;
  logic display_mode_sel_lo = 0, disp_wr = 0, alloc_wr = 0, alloc_rd = 0;
  logic [1:0] frame_freq_sel = 0;
  logic [4:0] duty_sel = 0;
  logic [7:0] disp_addr = 0, disp_wdata = 0, alloc_wdata = 0, alloc_rdata;
  logic [9:0] alloc_addr = 0;
  logic bias_gen_on, bias_third, mult_locked, drivers_on;
  logic [23:0] com_out;
  logic [63:0] seg_out;
  logic [4:0] lit_com;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  lcd_drive_segment_allocation #(.FRAME_CYC_64(48), .FRAME_CYC_73(44),
    .FRAME_CYC_85(40), .FRAME_CYC_102(36)) DUT (.*);
  lcd_panel_model panel (.com_out, .lit_com);
  initial
    forever #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic arr, logic [9:0] a, logic [7:0] d);
    @(negedge core_clk);
    {alloc_wr, disp_wr, alloc_addr, disp_addr} = {arr, !arr, a, a[7:0]};
    {alloc_wdata, disp_wdata} = {d, d};
    @(negedge core_clk);
    {alloc_wr, disp_wr} = 2'h0;
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] want);
    @(negedge core_clk) {alloc_rd, alloc_addr} = {1'b1, a};
    @(negedge core_clk) alloc_rd = 0;
    chk("alloc read", want, alloc_rdata);
  endtask
  // waits past any config change, then judges masked segments at common 0
  task automatic pix(logic [63:0] m, logic [63:0] w);
    repeat (3) @(negedge core_clk);
    repeat (200) if (com_out !== 24'h00_0001) @(negedge core_clk);
    chk("pixel", w, seg_out & m);
  endtask
  task automatic t_ram();
    chk("reset outputs", 0, {bias_gen_on, drivers_on, com_out});
    chk("reset segments", 0, seg_out);
    wr(1, 10'h013, 8'h17);
    wr(1, 10'h3ff, 8'ha5);
    rd(10'h013, 8'h17);
    rd(10'h3ff, 8'ha5);
    alloc_enable_bit = 1;
    wr(1, 10'h013, 8'hff);
    rd(10'h013, 8'h00);
    alloc_enable_bit = 0;
    rd(10'h013, 8'h17);
    $display("ram test done");
  endtask
  task automatic t_maps();
    logic [7:0] wa [6] = '{8'h05, 8'h06, 8'h0a, 8'h0c, 8'h0f, 8'h12};
    logic [5:0] wd = 6'h39;
    foreach (wa[i])
      wr(0, {2'h0, wa[i]}, {7'h00, wd[i]});
    {bias_third_sel, bias_mult_lock, bias_on_bit, duty_sel} = {3'h7, 5'h07};
    repeat (TBIAS) @(negedge core_clk);
    chk("before display", 0, {drivers_on, com_out});
    chk("bias", 3'h7, {bias_gen_on, bias_third, mult_locked});
    display_mode_sel_lo = 1;
    {map_type_sel_hi, map_type_sel_lo} = 2'h2;
    pix(64'h60, 64'h20);
    {map_type_sel_hi, map_type_sel_lo} = 2'h1;
    duty_sel = 5'h0f;
    pix(64'h60, 64'h40);
    map_type_sel_lo = 1'b0;
    duty_sel = 5'h17;
    pix(64'h60, 64'h60);
    repeat (20) if (com_out[0]) @(negedge core_clk);
    chk("next common", 1, lit_com);
    display_mode_sel_lo = 0;
    repeat (3) @(negedge core_clk);
    chk("display off", 0, {drivers_on, com_out});
    $display("fixed map test done");
  endtask
  task automatic t_alloc();
    logic [7:0] cs [6] = '{8'h0f, 8'h10, 8'h4d, 8'h4e, 8'h8b, 8'hca};
    wr(1, 10'h018, 8'h17);
    wr(1, 10'h218, 8'h06);
    wr(0, 10'h017, 8'h40);
    wr(0, 10'h003, 8'h00);
    // quarter bias from here on
    {bias_third_sel, alloc_enable_bit, map_type_sel_hi,
     display_mode_sel_hi} = 4'h7;
    foreach (cs[i])
    begin
      {frame_freq_sel, duty_sel} = cs[i][7:1];
      pix(64'h8, {60'h0, cs[i][0], 3'h0});
    end
    chk("quarter bias", 3'h5, {bias_gen_on, bias_third, mult_locked});
    $display("allocation test done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge core_clk);
    rstn = 1;
    @(negedge core_clk);
    t_ram();
    t_maps();
    t_alloc();
    print_verdict();
  end
endmodule
